/* File: hdl/uefl_top.sv */
// endpoint zero-length and nak flags with masks behind an apb slave
`timescale 1ns/100ps
`include "uefl_consts.svh"
module uefl_top #(
  parameter int ADDR_W = 12,
  parameter int NUM_EP = 8
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [3:0]            pstrb,
  input  wire uefl_pkg::uefl_word_t  pwdata,
  output      uefl_pkg::uefl_word_t  prdata,
  output logic                       pready,
  output logic                       pslverr,
  // protocol engine events
  input  wire uefl_pkg::uefl_ep_vec_t zero_len_rx,
  input  wire uefl_pkg::uefl_stage_t  ep0_stage,
  input  wire uefl_pkg::uefl_ep_vec_t nak_sent,
  // interrupt outputs
  output logic                       int_rx_zero,
  output logic                       int_nak
);
  import uefl_pkg::*;

  // elaboration-time refusal of parameter values the logic cannot serve
  if (NUM_EP != 8 || ADDR_W < 4) begin : g_bad_params
    $error("uefl_top: NUM_EP must be 8 and ADDR_W at least 4");
  end

  // *****************************************************************************
  // address decode
  // *****************************************************************************
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [11:0] a12;
    a12 = 12'(a);
    if (a12 == `UEFL_ADDR_ZLRX) begin
      decode = 3'h1;
    end else if (a12 == `UEFL_ADDR_NAK) begin
      decode = 3'h2;
    end else if (a12 == `UEFL_ADDR_EPMSK) begin
      decode = 3'h3;
    end else if (a12 == `UEFL_ADDR_NAKMSK) begin
      decode = 3'h4;
    end else begin
      decode = 3'h0;
    end
  endfunction : decode

  // *****************************************************************************
  // register state
  // *****************************************************************************
  uefl_ep_vec_t zero_length_rx_flags;
  uefl_ep_vec_t nak_sent_flags;
  uefl_ep_vec_t endpoint_flag_mask_register;
  uefl_ep_vec_t nak_mask_register;
  uefl_ep_vec_t next_zero_length_rx_flags;
  uefl_ep_vec_t next_nak_sent_flags;
  uefl_ep_vec_t next_endpoint_flag_mask_register;
  uefl_ep_vec_t next_nak_mask_register;
  uefl_word_t   next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         next_int_rx_zero;
  logic         next_int_nak;
  logic         access;
  logic [2:0]   sel;
  logic         wr_lo;
  uefl_ep_vec_t zl_set;
  uefl_ep_vec_t nak_set;

  assign access = psel && penable && !pready;
  assign sel    = decode(paddr);
  assign wr_lo  = access && pwrite && pstrb[0];

  // *****************************************************************************
  // next state
  // *****************************************************************************
  always_comb begin
    zl_set    = zero_len_rx;
    zl_set[0] = zero_len_rx[0] && (ep0_stage == UEFL_STAGE_DATA);
    nak_set   = nak_sent & `UEFL_NAK_VALID;
    next_zero_length_rx_flags        = zero_length_rx_flags;
    next_nak_sent_flags              = nak_sent_flags;
    next_endpoint_flag_mask_register = endpoint_flag_mask_register;
    next_nak_mask_register           = nak_mask_register;
    if (wr_lo && sel == 3'h1) begin
      next_zero_length_rx_flags = zero_length_rx_flags & ~pwdata[7:0];
    end
    if (wr_lo && sel == 3'h2) begin
      next_nak_sent_flags = nak_sent_flags & ~pwdata[7:0];
    end
    if (wr_lo && sel == 3'h3) begin
      next_endpoint_flag_mask_register = pwdata[7:0];
    end
    if (wr_lo && sel == 3'h4) begin
      next_nak_mask_register = pwdata[7:0] & `UEFL_NAK_VALID;
    end
    // set wins over a clear in the same cycle
    next_zero_length_rx_flags = next_zero_length_rx_flags | zl_set;
    next_nak_sent_flags       = next_nak_sent_flags | nak_set;
    next_pready  = access;
    next_pslverr = access && (sel == 3'h0);
    next_prdata  = 32'h0000_0000;
    if (access && !pwrite) begin
      if (sel == 3'h1) begin
        next_prdata = {24'h00_0000, zero_length_rx_flags};
      end else if (sel == 3'h2) begin
        next_prdata = {24'h00_0000, nak_sent_flags};
      end else if (sel == 3'h3) begin
        next_prdata = {24'h00_0000, endpoint_flag_mask_register};
      end else if (sel == 3'h4) begin
        next_prdata = {24'h00_0000, nak_mask_register};
      end
    end
    next_int_rx_zero = |(next_zero_length_rx_flags & ~next_endpoint_flag_mask_register);
    next_int_nak     = |(next_nak_sent_flags & ~next_nak_mask_register & `UEFL_NAK_VALID);
  end

  // *****************************************************************************
  // registers
  // *****************************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_length_rx_flags        <= `UEFL_ZLRX_RESET;
      nak_sent_flags              <= `UEFL_NAK_RESET;
      endpoint_flag_mask_register <= `UEFL_MSK_RESET;
      nak_mask_register           <= `UEFL_MSK_RESET;
      prdata                      <= 32'h0000_0000;
      pready                      <= 1'b0;
      pslverr                     <= 1'b0;
      int_rx_zero                 <= 1'b0;
      int_nak                     <= 1'b0;
    end else begin
      zero_length_rx_flags        <= next_zero_length_rx_flags;
      nak_sent_flags              <= next_nak_sent_flags;
      endpoint_flag_mask_register <= next_endpoint_flag_mask_register;
      nak_mask_register           <= next_nak_mask_register;
      prdata                      <= next_prdata;
      pready                      <= next_pready;
      pslverr                     <= next_pslverr;
      int_rx_zero                 <= next_int_rx_zero;
      int_nak                     <= next_int_nak;
    end
  end

  // *****************************************************************************
  // checks
  // *****************************************************************************
  sequence s_zl_event(int i);
    zero_len_rx[i] && (i != 0 || ep0_stage == UEFL_STAGE_DATA);
  endsequence

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable;
  endsequence

  AST_ZL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    zero_len_rx[3] |=> zero_length_rx_flags[3])
    else $error("zero-length flag 3 not set");
  AST_EP0_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    s_zl_event(0) |=> zero_length_rx_flags[0])
    else $error("ep0 data-stage zero-length not flagged");
  AST_EP0_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
    (zero_len_rx[0] && ep0_stage == UEFL_STAGE_STATUS && !zero_length_rx_flags[0]) |=> !zero_length_rx_flags[0])
    else $error("ep0 status-stage zero-length set flag");
  AST_NAK_SET: assert property (@(posedge pclk) disable iff (!presetn)
    nak_sent[5] |=> nak_sent_flags[5] && !nak_sent_flags[0])
    else $error("nak flag wrong");
  AST_ZL_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    int_rx_zero == |(zero_length_rx_flags & ~endpoint_flag_mask_register))
    else $error("zero-length interrupt does not match flags and mask");
  AST_NAK_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    int_nak == |(nak_sent_flags & ~nak_mask_register))
    else $error("nak interrupt does not match flags and mask");
  AST_MASK_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    (nak_sent[2] && nak_mask_register == 8'hFE && !wr_lo) |=> nak_sent_flags[2] && !int_nak)
    else $error("masked nak flag lost or interrupt raised");
  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && sel == 3'h2 && pwdata[7:0] == 8'h02 && !nak_sent[1] && !nak_sent[4] && nak_sent_flags[4])
      |=> !nak_sent_flags[1] && nak_sent_flags[4])
    else $error("write-one-to-clear disturbed other flags");
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup ##1 s_apb_access |-> ##1 pready)
    else $error("apb answer late");

  // *****************************************************************************
  // response, nak bit-0, masked zero-length and clear checks
  // *****************************************************************************
  AST_ERR_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response without ready");
  AST_RDATA_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside a response");
  AST_NAK_BIT0: assert property (@(posedge pclk) disable iff (!presetn)
    !nak_sent_flags[0] && !nak_mask_register[0])
    else $error("nak bit 0 not held at 0");
  AST_ZL_MASK_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    (zero_len_rx[5] && endpoint_flag_mask_register == 8'hFF && !wr_lo)
      |=> zero_length_rx_flags[5] && !int_rx_zero)
    else $error("masked zero-length flag lost or interrupt raised");
  AST_ZL_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && sel == 3'h1 && zero_len_rx == 8'h00)
      |=> zero_length_rx_flags == ($past(zero_length_rx_flags) & ~$past(pwdata[7:0])))
    else $error("zero-length clear changed the wrong flags");

  // *****************************************************************************
  // per-endpoint set checks
  // *****************************************************************************
  for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
    AST_ZL_EP: assert property (@(posedge pclk) disable iff (!presetn)
      s_zl_event(g) |=> zero_length_rx_flags[g])
      else $error("zero-length flag of an endpoint not set");
    if (g > 0) begin : g_nak
      AST_NAK_EP: assert property (@(posedge pclk) disable iff (!presetn)
        nak_sent[g] |=> nak_sent_flags[g])
        else $error("nak flag of an endpoint not set");
    end
  end
endmodule : uefl_top

/* File: hdl/uefl_consts.svh */
// constants of the usb endpoint event flag block
// *****************************************************************************
// *****************************************************************************
`ifndef UEFL_CONSTS_SVH
`define UEFL_CONSTS_SVH
`define UEFL_ADDR_ZLRX     12'h000
`define UEFL_ADDR_NAK      12'h004
`define UEFL_ADDR_EPMSK    12'h008
`define UEFL_ADDR_NAKMSK   12'h00C
`define UEFL_ZLRX_RESET    8'h00
`define UEFL_NAK_RESET     8'h00
`define UEFL_MSK_RESET     8'h00
`define UEFL_NAK_VALID     8'hFE
`endif

/* File: hdl/uefl_pkg.sv */
// types of the usb endpoint event flag block
package uefl_pkg;
  typedef logic [7:0]  uefl_ep_vec_t;
  typedef logic [31:0] uefl_word_t;
  typedef enum logic [1:0] {
    UEFL_STAGE_IDLE   = 2'b00,
    UEFL_STAGE_SETUP  = 2'b01,
    UEFL_STAGE_DATA   = 2'b10,
    UEFL_STAGE_STATUS = 2'b11
  } uefl_stage_t;
endpackage : uefl_pkg

/* File: tb/uefl_engine_model.sv */
// protocol engine model that raises endpoint event pulses
`timescale 1ns/100ps
module uefl_engine_model (
  // clock
  input  wire logic              pclk,
  // endpoint events
  output uefl_pkg::uefl_ep_vec_t zero_len_rx,
  output uefl_pkg::uefl_stage_t  ep0_stage,
  output uefl_pkg::uefl_ep_vec_t nak_sent
);
  import uefl_pkg::*;
  initial begin
    zero_len_rx = '0;
    ep0_stage   = UEFL_STAGE_IDLE;
    nak_sent    = '0;
  end
  // one-cycle pulses, stage kept as a level
  task automatic send(input uefl_ep_vec_t zl, input uefl_stage_t st, input uefl_ep_vec_t nk);
    @(posedge pclk);
    zero_len_rx <= zl;
    ep0_stage   <= st;
    nak_sent    <= nk;
    @(posedge pclk);
    zero_len_rx <= '0;
    nak_sent    <= '0;
  endtask : send
endmodule : uefl_engine_model

/* File: tb/tb_usb_endpoint_event_flags.sv */
// self-checking bench of the endpoint event flag block
`timescale 1ns/100ps
`include "uefl_consts.svh"
module tb_usb_endpoint_event_flags;
  import uefl_pkg::*;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [3:0]   pstrb = 4'hF;
  uefl_word_t   pwdata = '0, prdata;
  logic         pready, pslverr, int_rx_zero, int_nak;
  uefl_ep_vec_t zero_len_rx, nak_sent, zl_exp = '0, nk_exp = '0, zm = '0, nm = '0, r8;
  uefl_stage_t  ep0_stage;
  logic [15:0]  seed = 16'h4212;
  logic [32:0]  rq[$];
  int           bad_count = 0, n_compared = 0, k;
  always #5 pclk = ~pclk;
  uefl_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_len_rx(zero_len_rx), .ep0_stage(ep0_stage), .nak_sent(nak_sent),
    .int_rx_zero(int_rx_zero), .int_nak(int_nak));
  uefl_engine_model ENG (.pclk(pclk), .zero_len_rx(zero_len_rx), .ep0_stage(ep0_stage), .nak_sent(nak_sent));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report;
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // apb master, expected {pslverr, read data} noted in the queue
  task automatic apb(input logic wr, input logic [11:0] a, input uefl_word_t d, input logic [32:0] e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic icheck;
    @(negedge pclk);
    check({32'h0, int_rx_zero}, {32'h0, |(zl_exp & ~zm)});
    check({32'h0, int_nak}, {32'h0, |(nk_exp & ~nm & 8'hFE)});
  endtask : icheck
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) check({pslverr, pwrite ? 32'h0 : prdata}, rq.pop_front());
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 4; k++) apb(1'b0, 12'(4 * k), '0, '0);
    apb(1'b0, 12'h010, '0, {1'b1, 32'h0});
    zm = 8'h06;
    nm = 8'h06;
    apb(1'b1, `UEFL_ADDR_EPMSK, {24'h0, zm}, '0);
    apb(1'b1, `UEFL_ADDR_NAKMSK, {24'h0, nm}, '0);
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      ENG.send(seed[7:0] | 8'h01, uefl_stage_t'(k[1:0]), seed[15:8] | 8'h01);
      zl_exp |= (seed[7:0] | 8'h01) & ((k[1:0] == 2'b10) ? 8'hFF : 8'hFE);
      nk_exp |= seed[15:8] & 8'hFE;
      icheck();
      apb(1'b0, `UEFL_ADDR_ZLRX, '0, {25'h0, zl_exp});
      apb(1'b0, `UEFL_ADDR_NAK, '0, {25'h0, nk_exp});
      seed = lfsr(seed);
      zm = seed[7:0];
      nm = seed[15:8] & 8'hFE;
      apb(1'b1, `UEFL_ADDR_EPMSK, {24'h0, zm}, '0);
      apb(1'b1, `UEFL_ADDR_NAKMSK, {16'h0, seed[15:8], 8'h0} >> 8, '0);
      icheck();
      r8 = 8'(lfsr(seed) >> 4);
      apb(1'b1, `UEFL_ADDR_ZLRX, {24'h0, r8}, '0);
      apb(1'b1, `UEFL_ADDR_NAK, {24'h0, ~r8}, '0);
      zl_exp &= ~r8;
      nk_exp &= r8;
      icheck();
    end
    // everything masked: flags still set, interrupts stay low, then a single-bit clear
    zm = 8'hFF;
    nm = 8'hFE;
    apb(1'b1, `UEFL_ADDR_EPMSK, {24'h0, zm}, '0);
    apb(1'b1, `UEFL_ADDR_NAKMSK, {24'h0, nm}, '0);
    ENG.send(8'h20, UEFL_STAGE_DATA, 8'h14);
    zl_exp |= 8'h20;
    nk_exp |= 8'h14;
    icheck();
    apb(1'b1, `UEFL_ADDR_NAK, 32'h0000_0002, '0);
    nk_exp &= 8'hFD;
    apb(1'b0, `UEFL_ADDR_NAK, '0, {25'h0, nk_exp});
    apb(1'b0, `UEFL_ADDR_ZLRX, '0, {25'h0, zl_exp});
    apb(1'b0, `UEFL_ADDR_NAKMSK, '0, {25'h0, nm});
    pstrb <= 4'h0;
    apb(1'b1, `UEFL_ADDR_EPMSK, ~zm, '0);
    pstrb <= 4'hF;
    apb(1'b0, `UEFL_ADDR_EPMSK, '0, {25'h0, zm});
    // reset in mid-run: flags, masks and interrupts all return to 0
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    zl_exp = '0;
    nk_exp = '0;
    zm = '0;
    nm = '0;
    icheck();
    for (k = 0; k < 4; k++) apb(1'b0, 12'(4 * k), '0, '0);
    repeat (3) @(posedge pclk);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    final_report();
  end
endmodule : tb_usb_endpoint_event_flags
